/* File: common/psv_cfg.svh */
`ifndef PSV_CFG_SVH
`define PSV_CFG_SVH
// ---------------------------------------------------------------------------
// Program space geometry
// ---------------------------------------------------------------------------
`define PSV_PC_W        21
`define PSV_SP_W        5
`define PSV_INSN_W      16
`define PSV_RESET_VEC   21'h000000
`define PSV_VEC_HI      21'h000008
`define PSV_VEC_LO      21'h000018
`define PSV_BOOT_TOP    21'h0007ff
`define PSV_PC_STEP     21'h000002
`define PSV_FLASH_SMALL 49152
`define PSV_FLASH_LARGE 65536
// ---------------------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------------------
`define PSV_ADDR_W      8
`define PSV_OFS_CTRL    8'h00
`define PSV_OFS_PC      8'h04
`define PSV_OFS_TOS     8'h08
`define PSV_OFS_SP      8'h0c
`define PSV_OFS_WAKE    8'h10
`define PSV_OFS_EXTBUS  8'h14
`define PSV_OFS_MODE    8'h18
`define PSV_BIT_LOW_PRIORITY_GLOBAL_IRQ_ENABLE    0
`define PSV_BIT_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE    1
`define PSV_BIT_WK_WDT  0
`define PSV_BIT_WK_IRQ  1
`define PSV_EXTBUS_W    8
`define PSV_RESP_OKAY   2'h0
`define PSV_RESP_SLVERR 2'h2
`endif

/* File: common/psv_pkg.sv */
package psv_pkg;
  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSV_MODE_EXT_FLASH = 2'h0, // Flash then external
    PSV_MODE_BOOT_EXT  = 2'h1, // Boot block then external
    PSV_MODE_EXT_ONLY  = 2'h2, // External only
    PSV_MODE_CHIP_ONLY = 2'h3  // On-chip only
  } psv_mode_t;
  typedef enum logic [1:0] {
    PSV_ST_RUN   = 2'h0,
    PSV_ST_SLEEP = 2'h1,
    PSV_ST_WAKE  = 2'h3
  } psv_state_t;
  typedef enum logic [1:0] {
    PSV_SRC_ZERO = 2'h0,
    PSV_SRC_INT  = 2'h1,
    PSV_SRC_EXT  = 2'h2
  } psv_src_t;
endpackage : psv_pkg

/* File: core/psv_top.sv */
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "psv_cfg.svh"
module psv_top #(
  parameter int FLASH_BYTES = `PSV_FLASH_LARGE,
  parameter bit HAS_EXT_BUS = 1'b1
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Configuration strap (pins)
  input  wire logic [1:0]                 program_memory_mode_select,
  // Core sequencing
  input  wire logic                       fetch_en,
  input  wire logic                       pc_load_valid,
  input  wire logic [`PSV_PC_W-1:0]       pc_load_addr,
  input  wire logic                       sleep_req,
  input  wire logic                       wake_irq,
  input  wire logic                       wake_irq_high,
  input  wire logic                       wake_wdt,
  // Program memory side
  output logic [`PSV_PC_W-1:0]            prog_addr,
  output logic                            flash_rd,
  output logic                            ext_rd,
  input  wire logic [`PSV_INSN_W-1:0]     flash_rdata,
  input  wire logic [`PSV_INSN_W-1:0]     ext_rdata,
  output logic [`PSV_INSN_W-1:0]          insn,
  output logic                            insn_valid,
  output logic                            asleep,
  // AXI4-Lite slave
  input  wire logic [`PSV_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [`PSV_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  import psv_pkg::*;

  // -------------------------------------------------------------------------
  // Elaboration checks and limits
  // -------------------------------------------------------------------------
  if (FLASH_BYTES != `PSV_FLASH_SMALL && FLASH_BYTES != `PSV_FLASH_LARGE) begin : g_bad_flash
    $error("FLASH_BYTES must be 48K or 64K");
  end
  localparam logic [`PSV_PC_W-1:0] FLASH_LIMIT = `PSV_PC_W'(FLASH_BYTES);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  logic [1:0]                mode_meta_reg;
  psv_mode_t                 mode_reg;
  psv_mode_t                 mode_eff;
  psv_state_t                state_reg;
  psv_state_t                state_next;
  logic [`PSV_PC_W-1:0]      pc_reg;
  logic [`PSV_PC_W-1:0]      tos_reg;
  logic [`PSV_SP_W-1:0]      sp_reg;
  logic                      low_priority_global_irq_enable_reg;
  logic                      high_priority_global_irq_enable_reg;
  logic                      wk_wdt_reg;
  logic                      wk_irq_reg;
  logic                      wk_high_reg;
  logic [`PSV_EXTBUS_W-1:0]  extbus_reg;
  psv_src_t                  src_reg;
  psv_src_t                  src_next;
  logic                      issued_reg;
  logic                      fetch_go;
  logic                      vec_take;
  logic [`PSV_PC_W-1:0]      vec_addr;
  logic                      wr_go;
  logic                      rd_go;
  logic [31:0]               rd_data;
  logic                      rd_hit;
  logic                      wr_hit;

  // Strap synchroniser; variant without external bus (HAS_EXT_BUS off) is fixed to on-chip only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_meta_reg <= PSV_MODE_CHIP_ONLY;
      mode_reg      <= PSV_MODE_CHIP_ONLY;
    end else begin
      mode_meta_reg <= program_memory_mode_select;
      mode_reg      <= psv_mode_t'(mode_meta_reg);
    end
  end
  assign mode_eff = HAS_EXT_BUS ? mode_reg : PSV_MODE_CHIP_ONLY;

  // -------------------------------------------------------------------------
  // Fetch routing
  // -------------------------------------------------------------------------
  assign fetch_go = aresetn && (state_reg == PSV_ST_RUN) && fetch_en;
  // Source decode of the current PC
  always_comb begin
    unique case (mode_eff)
      PSV_MODE_CHIP_ONLY: src_next = (pc_reg < FLASH_LIMIT) ? PSV_SRC_INT : PSV_SRC_ZERO;
      PSV_MODE_EXT_ONLY:  src_next = PSV_SRC_EXT;
      PSV_MODE_BOOT_EXT:  src_next = (pc_reg <= `PSV_BOOT_TOP) ? PSV_SRC_INT : PSV_SRC_EXT;
      PSV_MODE_EXT_FLASH: src_next = (pc_reg < FLASH_LIMIT) ? PSV_SRC_INT : PSV_SRC_EXT;
    endcase
  end
  // Issue stage: remember where the fetch went
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_reg    <= PSV_SRC_ZERO;
      issued_reg <= 1'b0;
      flash_rd   <= 1'b0;
      ext_rd     <= 1'b0;
    end else begin
      src_reg    <= src_next;
      issued_reg <= fetch_go;
      flash_rd   <= fetch_go && (src_next == PSV_SRC_INT);
      ext_rd     <= fetch_go && (src_next == PSV_SRC_EXT);
    end
  end
  // Return stage: zero substitution never stalls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insn       <= '0;
      insn_valid <= 1'b0;
    end else begin
      insn_valid <= issued_reg;
      unique case (src_reg)
        PSV_SRC_INT: insn <= flash_rdata;
        PSV_SRC_EXT: insn <= ext_rdata;
        default:     insn <= '0;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Sleep and wake sequencing
  // -------------------------------------------------------------------------
  assign vec_take = (state_reg == PSV_ST_WAKE) && wk_irq_reg &&
                    (wk_high_reg ? high_priority_global_irq_enable_reg : low_priority_global_irq_enable_reg);
  assign vec_addr = wk_high_reg ? `PSV_VEC_HI : `PSV_VEC_LO;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PSV_ST_RUN:   if (sleep_req) state_next = PSV_ST_SLEEP;
      PSV_ST_SLEEP: if (wake_irq || wake_wdt) state_next = PSV_ST_WAKE;
      PSV_ST_WAKE:  state_next = PSV_ST_RUN;
      default:      state_next = PSV_ST_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= PSV_ST_RUN;
      wk_high_reg <= 1'b0;
      asleep      <= 1'b0;
    end else begin
      state_reg <= state_next;
      asleep    <= (state_next == PSV_ST_SLEEP);
      if (state_reg == PSV_ST_SLEEP && wake_irq) begin
        wk_high_reg <= wake_irq_high;
      end
    end
  end

  // Program counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_reg <= `PSV_RESET_VEC;
    end else if (vec_take) begin
      pc_reg <= vec_addr;
    end else if (fetch_go) begin
      pc_reg <= pc_load_valid ? pc_load_addr : pc_reg + `PSV_PC_STEP;
    end
  end
  assign prog_addr = pc_reg;
  // Top-of-stack and stack pointer: push on vectored wake, else software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tos_reg <= '0;
      sp_reg  <= '0;
    end else if (vec_take) begin
      tos_reg <= pc_reg;
      sp_reg  <= sp_reg + `PSV_SP_W'(1);
    end else if (wr_go && s_axi_awaddr == `PSV_OFS_TOS) begin
      tos_reg <= s_axi_wdata[`PSV_PC_W-1:0];
    end else if (wr_go && s_axi_awaddr == `PSV_OFS_SP) begin
      sp_reg  <= s_axi_wdata[`PSV_SP_W-1:0];
    end
  end
  // Wake cause flags, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wk_wdt_reg <= 1'b0;
      wk_irq_reg <= 1'b0;
    end else begin
      if (state_reg == PSV_ST_SLEEP && wake_wdt) begin
        wk_wdt_reg <= 1'b1;
      end else if (wr_go && s_axi_awaddr == `PSV_OFS_WAKE && s_axi_wdata[`PSV_BIT_WK_WDT]) begin
        wk_wdt_reg <= 1'b0;
      end
      if (state_reg == PSV_ST_SLEEP && wake_irq) begin
        wk_irq_reg <= 1'b1;
      end else if (wr_go && s_axi_awaddr == `PSV_OFS_WAKE && s_axi_wdata[`PSV_BIT_WK_IRQ]) begin
        wk_irq_reg <= 1'b0;
      end
    end
  end
  // Control and external bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_priority_global_irq_enable_reg   <= 1'b0;
      high_priority_global_irq_enable_reg   <= 1'b0;
      extbus_reg <= '0;
    end else if (wr_go && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == `PSV_OFS_CTRL) begin
        low_priority_global_irq_enable_reg <= s_axi_wdata[`PSV_BIT_LOW_PRIORITY_GLOBAL_IRQ_ENABLE];
        high_priority_global_irq_enable_reg <= s_axi_wdata[`PSV_BIT_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE];
      end
      if (s_axi_awaddr == `PSV_OFS_EXTBUS && mode_eff != PSV_MODE_CHIP_ONLY) begin
        extbus_reg <= s_axi_wdata[`PSV_EXTBUS_W-1:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // AXI4-Lite slave
  // -------------------------------------------------------------------------
  assign wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  assign rd_go  = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  assign wr_hit = s_axi_awaddr inside {`PSV_OFS_CTRL, `PSV_OFS_TOS, `PSV_OFS_SP,
                                       `PSV_OFS_WAKE, `PSV_OFS_EXTBUS};
  // Read mux
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      `PSV_OFS_CTRL:   rd_data = {30'h0, high_priority_global_irq_enable_reg, low_priority_global_irq_enable_reg};
      `PSV_OFS_PC:     rd_data = {11'h0, pc_reg};
      `PSV_OFS_TOS:    rd_data = {11'h0, tos_reg};
      `PSV_OFS_SP:     rd_data = {27'h0, sp_reg};
      `PSV_OFS_WAKE:   rd_data = {30'h0, wk_irq_reg, wk_wdt_reg};
      `PSV_OFS_EXTBUS: rd_data = (mode_eff == PSV_MODE_CHIP_ONLY) ? 32'h0 : {24'h0, extbus_reg};
      `PSV_OFS_MODE:   rd_data = {29'h0, HAS_EXT_BUS, mode_eff};
      default:         rd_hit  = 1'b0;
    endcase
  end
  // Write channel: both address and data taken in one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSV_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PSV_RESP_OKAY : `PSV_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `PSV_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_hit ? `PSV_RESP_OKAY : `PSV_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  chk_reset_vector: assert property (@(posedge aclk) !aresetn |=> pc_reg == `PSV_RESET_VEC)
    else $error("PC not at reset vector after reset");
  chk_pc_step: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_go && !pc_load_valid && !vec_take |=> pc_reg == `PSV_PC_W'($past(pc_reg) + `PSV_PC_STEP))
    else $error("PC did not advance by one word");
  chk_zero_fill: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_go && mode_eff == PSV_MODE_CHIP_ONLY && pc_reg >= FLASH_LIMIT |=> ##1 insn_valid && insn == '0)
    else $error("Out-of-range fetch did not return zero");
  chk_no_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_go |=> issued_reg ##1 insn_valid)
    else $error("Fetch answer not two cycles later");
  chk_boot_split: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_go && mode_eff == PSV_MODE_BOOT_EXT |=>
      (flash_rd == ($past(pc_reg) <= `PSV_BOOT_TOP)) && (ext_rd != flash_rd))
    else $error("Boot block split wrong");
  chk_ext_only: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_go && mode_eff == PSV_MODE_EXT_ONLY |=> ext_rd && !flash_rd)
    else $error("External-only mode touched flash");
  chk_vector_load: assert property (@(posedge aclk) disable iff (!aresetn)
    vec_take |=> pc_reg == (wk_high_reg ? `PSV_VEC_HI : `PSV_VEC_LO) && state_reg == PSV_ST_RUN)
    else $error("Wake did not load interrupt vector");
  chk_tos_push: assert property (@(posedge aclk) disable iff (!aresetn)
    vec_take |=> tos_reg == $past(pc_reg) && sp_reg == `PSV_SP_W'($past(sp_reg) + 1))
    else $error("Wake did not push PC");
  chk_wake_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == PSV_ST_SLEEP && (wake_irq || wake_wdt) |=> (wk_irq_reg || wk_wdt_reg) && state_reg == PSV_ST_WAKE)
    else $error("Wake left no cause bit");
  chk_extbus_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && s_axi_araddr == `PSV_OFS_EXTBUS && mode_eff == PSV_MODE_CHIP_ONLY |=> s_axi_rvalid && s_axi_rdata == '0)
    else $error("External bus control not zero in on-chip mode");
endmodule : psv_top

/* File: dv/psv_prog_mem_model.sv */
`timescale 1ns/1ps
`include "psv_cfg.svh"
module psv_prog_mem_model (
  // Clock
  input  wire logic                   aclk,
  // Fetch side of the block
  input  wire logic [`PSV_PC_W-1:0]   prog_addr,
  input  wire logic                   flash_rd,
  input  wire logic                   ext_rd,
  // Read data back to the block
  output logic      [`PSV_INSN_W-1:0] flash_rdata,
  output logic      [`PSV_INSN_W-1:0] ext_rdata
);
  logic [`PSV_PC_W-1:0]   addr_q;
  logic [`PSV_INSN_W-1:0] idle_q = 16'h1234;
  // Fetch address taken at the last edge; idle pattern moves every cycle
  always @(posedge aclk) begin
    addr_q <= prog_addr;
    idle_q <= idle_q + 16'h3b1d;
  end
  // Data only in the read cycle, so a stale word can never pass for a fetch
  assign flash_rdata = flash_rd ? (addr_q[15:0] ^ 16'h5a5b) : idle_q;
  assign ext_rdata   = ext_rd ? (addr_q[15:0] ^ 16'hc3c3) : ~idle_q;
endmodule : psv_prog_mem_model

/* File: dv/test_program_space_vectoring.sv */
`timescale 1ns/1ps
`include "psv_cfg.svh"
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module test_program_space_vectoring;
  import psv_pkg::*;
  typedef struct {logic [1:0] mode; logic [20:0] addr; psv_src_t src;} psv_fetch_row_t;
  typedef struct {logic [1:0] ctrl; logic [2:0] wk; logic [20:0] pc; logic [20:0] tos; logic [4:0] sp;
                  logic [1:0] cause;} psv_wake_row_t;
  logic        aclk, aresetn, fetch_en, pc_load_valid, sleep_req, wake_irq, wake_irq_high, wake_wdt;
  logic [1:0]  program_memory_mode_select, s_axi_bresp, s_axi_rresp, resp;
  logic [20:0] pc_load_addr, prog_addr;
  logic [15:0] flash_rdata, ext_rdata, insn;
  logic        flash_rd, ext_rd, insn_valid, asleep;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          errors, num_checks;
  // Fetch cases: strap mode, fetch address, which memory must serve it
  psv_fetch_row_t fetch_rows [10] = '{
    '{2'h3, 21'h000100, PSV_SRC_INT}, '{2'h3, 21'h00bffe, PSV_SRC_INT}, '{2'h3, 21'h00c000, PSV_SRC_ZERO},
    '{2'h3, 21'h1ffffe, PSV_SRC_ZERO}, '{2'h2, 21'h000100, PSV_SRC_EXT}, '{2'h1, 21'h0007fe, PSV_SRC_INT},
    '{2'h1, 21'h000800, PSV_SRC_EXT}, '{2'h0, 21'h00bffe, PSV_SRC_INT}, '{2'h0, 21'h00c000, PSV_SRC_EXT},
    '{2'h3, 21'h000124, PSV_SRC_INT}};
  // Wake cases: enables, {irq, high, wdt}, then PC, top of stack, pointer, cause
  psv_wake_row_t wake_rows [4] = '{
    '{2'h3, 3'b110, 21'h8, 21'h126, 5'h1, 2'h2}, '{2'h1, 3'b100, 21'h18, 21'h8, 5'h2, 2'h2},
    '{2'h1, 3'b110, 21'h18, 21'h8, 5'h2, 2'h2}, '{2'h2, 3'b001, 21'h18, 21'h8, 5'h2, 2'h1}};

  // ---------------------------------------------------------------------------
  // Block, memories and clock
  // ---------------------------------------------------------------------------
  psv_top #(.FLASH_BYTES(`PSV_FLASH_SMALL), .HAS_EXT_BUS(1'b1)) psv_top_i (
    .aclk, .aresetn, .program_memory_mode_select, .fetch_en, .pc_load_valid, .pc_load_addr, .sleep_req,
    .wake_irq, .wake_irq_high, .wake_wdt, .prog_addr, .flash_rd, .ext_rd, .flash_rdata, .ext_rdata, .insn,
    .insn_valid, .asleep, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  psv_prog_mem_model psv_prog_mem_model_i (
    .aclk, .prog_addr, .flash_rd, .ext_rd, .flash_rdata, .ext_rdata);
  always #5 aclk = ~aclk;

  // ---------------------------------------------------------------------------
  // Bus and sequencing tasks
  // ---------------------------------------------------------------------------
  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  // Read: data and response taken at the edge that shows rvalid
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, resp);
    `CHK("bresp", `PSV_RESP_OKAY, resp)
  endtask : wr_ok
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    axi_rd(a, rdat, resp);
    `CHK(what, exp, rdat)
    `CHK("rresp", `PSV_RESP_OKAY, resp)
  endtask : rd_chk
  task automatic set_mode(input logic [1:0] m);
    @(posedge aclk);
    program_memory_mode_select <= m;
    repeat (3) @(posedge aclk);
  endtask : set_mode
  // Load the PC, fetch once there, then follow the word to insn
  task automatic fetch_at(input psv_fetch_row_t r);
    logic [15:0] exp;
    exp = (r.src == PSV_SRC_INT) ? (r.addr[15:0] ^ 16'h5a5b) :
          (r.src == PSV_SRC_EXT) ? (r.addr[15:0] ^ 16'hc3c3) : 16'h0;
    set_mode(r.mode);
    fetch_en <= 1'b1;
    pc_load_valid <= 1'b1;
    pc_load_addr <= r.addr;
    @(posedge aclk);
    pc_load_valid <= 1'b0;
    #1 `CHK("prog_addr", r.addr, prog_addr)
    @(posedge aclk);
    fetch_en <= 1'b0;
    #1 `CHK("flash_rd", r.src == PSV_SRC_INT, flash_rd)
    `CHK("ext_rd", r.src == PSV_SRC_EXT, ext_rd)
    `CHK("pc_step", r.addr + `PSV_PC_STEP, prog_addr)
    @(posedge aclk);
    #1 `CHK("insn_valid", 1'b1, insn_valid)
    `CHK("insn", exp, insn)
  endtask : fetch_at
  // Sleep with fetch held high, wake, then check vector and stack state
  task automatic sleep_wake(input psv_wake_row_t w);
    wr_ok(`PSV_OFS_CTRL, {30'h0, w.ctrl});
    wr_ok(`PSV_OFS_WAKE, 32'h3);
    @(posedge aclk);
    sleep_req <= 1'b1;
    @(posedge aclk);
    sleep_req <= 1'b0;
    fetch_en <= 1'b1;
    @(posedge aclk);
    {wake_irq, wake_irq_high, wake_wdt} <= w.wk;
    #1 `CHK("asleep", 1'b1, asleep)
    `CHK("sleep_fetch", 1'b0, flash_rd)
    @(posedge aclk);
    {wake_irq, wake_irq_high, wake_wdt} <= 3'h0;
    fetch_en <= 1'b0;
    #1 `CHK("awake", 1'b0, asleep)
    repeat (2) @(posedge aclk);
    #1 `CHK("wake_pc", w.pc, prog_addr)
    rd_chk(`PSV_OFS_TOS, {11'h0, w.tos}, "tos");
    rd_chk(`PSV_OFS_SP, {27'h0, w.sp}, "sp");
    rd_chk(`PSV_OFS_WAKE, {30'h0, w.cause}, "cause");
  endtask : sleep_wake
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  // Main sequence: reset, fetch table, wake table, bus control, second reset
  initial begin
    {aclk, aresetn, fetch_en, pc_load_valid, sleep_req, wake_irq, wake_irq_high, wake_wdt} = 8'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pc_load_addr} = '0;
    s_axi_wstrb = 4'hf;
    program_memory_mode_select = 2'h3;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    #1 `CHK("reset_pc", 21'h0, prog_addr)
    foreach (fetch_rows[i]) fetch_at(fetch_rows[i]);
    $display("fetch table done");
    foreach (wake_rows[i]) sleep_wake(wake_rows[i]);
    $display("wake table done");
    set_mode(2'h0);
    wr_ok(`PSV_OFS_EXTBUS, 32'ha5);
    rd_chk(`PSV_OFS_EXTBUS, 32'ha5, "extbus");
    rd_chk(`PSV_OFS_MODE, 32'h4, "mode");
    set_mode(2'h3);
    rd_chk(`PSV_OFS_EXTBUS, 32'h0, "extbus_chip");
    rd_chk(`PSV_OFS_MODE, 32'h7, "mode_chip");
    axi_wr(8'h1c, 32'h1, resp);
    `CHK("bresp_unmapped", `PSV_RESP_SLVERR, resp)
    axi_rd(8'h1c, rdat, resp);
    `CHK("rresp_unmapped", `PSV_RESP_SLVERR, resp)
    `CHK("rdata_unmapped", 32'h0, rdat)
    // Fetches keep flowing while a register read is under way
    fetch_en <= 1'b1;
    rd_chk(`PSV_OFS_CTRL, 32'h2, "ctrl_busy");
    #1 `CHK("insn_busy", 1'b1, insn_valid)
    @(posedge aclk);
    fetch_en <= 1'b0;
    $display("register test done");
    @(posedge aclk);
    aresetn <= 1'b0;
    fetch_en <= 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1 `CHK("rereset_pc", 21'h0, prog_addr)
    @(posedge aclk);
    fetch_en <= 1'b0;
    rd_chk(`PSV_OFS_SP, 32'h0, "rereset_sp");
    $display("reset test done");
    end_sim;
  end
  // Watchdog on a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("watchdog expired");
    end_sim;
  end
endmodule : test_program_space_vectoring
